// ### dv/bfg_core_model.sv
/*
  stand-in for the core and flash array: command writes, stores, done.
  assumes the guard samples on the rising edge; drives on the falling one.
*/
module bfg_core_model #(
  parameter int AW = 14,
  parameter int DONE_CYC = 12
) (
  // clock and flash start
  input wire logic clk_in,
  input wire bfg_pkg::bfg_flash_req_t flash_req_in,
  // towards the guard
  output logic cmd_wr_out,
  output logic [4:0] cmd_data_out,
  output logic store_out,
  output logic [AW-1:0] store_addr_out,
  output bfg_pkg::bfg_lock_t lock_data_out,
  output logic flash_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0; // cycles left in the array operation
  initial begin
    cmd_wr_out = 1'h0;
    cmd_data_out = 5'h0;
    store_out = 1'h0;
    store_addr_out = '0;
    lock_data_out = 4'hF;
    flash_done_out = 1'h0;
  end
  task automatic program_memory_store(input logic [4:0] c, input logic [AW-1:0] a, input logic [3:0] l, input int gap);
    @(negedge clk_in);
    cmd_wr_out = 1'h1;
    cmd_data_out = c;
    @(negedge clk_in);
    cmd_wr_out = 1'h0;
    cmd_data_out = ~c; // stale value inverted, not held
    repeat (gap - 1) @(negedge clk_in);
    store_out = 1'h1;
    store_addr_out = a;
    lock_data_out = l;
    @(negedge clk_in);
    store_out = 1'h0;
    store_addr_out = ~a;
    lock_data_out = ~l;
  endtask : program_memory_store
  // done pulse a fixed time after each start; nba keeps readers race free
  always @(negedge clk_in) begin
    flash_done_out <= 1'h0;
    if (flash_req_in.start) begin
      cnt = DONE_CYC;
    end else if (cnt > 0) begin
      cnt--;
      flash_done_out <= (cnt == 0);
    end
  end
endmodule : bfg_core_model

// ### dv/bfg_guard_assertions.sv
/*
  port checker of the guard: stores, stalls, busy flag, locks, masks.
  assumes it is bound into bfg_guard and every input lives on clk_in.
*/
module bfg_guard_assertions #(
  parameter int AW = 14
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // watched inputs
  input wire logic [1:0] boot_size_fuses_in,
  input wire logic boot_reset_fuse_in,
  input wire logic vectors_in_boot_in,
  input wire logic [AW-1:0] exec_addr_in,
  input wire logic cmd_wr_in,
  input wire logic program_memory_store_in,
  input wire logic flash_done_in,
  input wire logic lock_load_in,
  input wire logic chip_erase_in,
  // watched outputs
  input wire bfg_pkg::bfg_flash_req_t flash_req_out,
  input wire logic core_halt_out,
  input wire logic rw_section_busy_flag_out,
  input wire logic rww_read_block_out,
  input wire logic store_refused_out,
  input wire logic irq_mask_out,
  input wire bfg_pkg::bfg_lock_t lock_bits_out,
  input wire logic [AW-1:0] reset_vector_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // first boot word per fuse setting, never below the halting start
  function automatic logic [AW-1:0] bstart(input logic [1:0] f);
    return (f == 2'h3) ? 14'h3F00 : (f == 2'h2) ? 14'h3E00 : (f == 2'h1) ? 14'h3C00 : 14'h3800;
  endfunction : bstart
  // core runs in the boot section
  logic ex_boot;
  assign ex_boot = exec_addr_in >= bstart(boot_size_fuses_in);
  // mask wanted when the vectors sit in the other section and reads are locked
  logic mask_want;
  assign mask_want = ex_boot ? (!vectors_in_boot_in && !lock_bits_out.boot_read_protect_bit)
                             : (vectors_in_boot_in && !lock_bits_out.app_read_protect_bit);
  // command write then a store from application code
  sequence s_app_store;
    cmd_wr_in ##1 program_memory_store_in && !cmd_wr_in && !ex_boot;
  endsequence
  a_app_store_ignored: assert property (s_app_store |=> store_refused_out && !flash_req_out.start)
    else $error("store from application code was acted on");
  a_busy_at_start: assert property (flash_req_out.start |-> rw_section_busy_flag_out)
    else $error("busy flag low at operation start");
  a_halt_by_page: assert property (flash_req_out.start |-> core_halt_out == (flash_req_out.page >= 14'h3800))
    else $error("halt does not match target section");
  a_halt_held: assert property (core_halt_out && !flash_done_in |=> core_halt_out)
    else $error("halt dropped before the operation ended");
  a_halt_ends: assert property (core_halt_out && flash_done_in |=> !core_halt_out)
    else $error("halt kept after the operation ended");
  a_block_is_busy: assert property (rww_read_block_out == rw_section_busy_flag_out)
    else $error("read block and busy flag differ");
  a_busy_sticky: assert property ($fell(rw_section_busy_flag_out) |-> $past(program_memory_store_in))
    else $error("busy flag cleared without a store");
  a_erase_restores: assert property (chip_erase_in |=> lock_bits_out == 4'hF)
    else $error("chip erase left lock bits programmed");
  a_lock_no_raise: assert property ((lock_bits_out & ~$past(lock_bits_out)) != 4'h0 |-> $past(chip_erase_in) || $past(lock_load_in))
    else $error("lock bit returned to unprogrammed");
  a_irq_mask_follow: assert property ($past(rst_n_in) |-> irq_mask_out == $past(mask_want))
    else $error("interrupt mask wrong");
  a_reset_vector: assert property ($past(rst_n_in) |-> reset_vector_out == $past(boot_reset_fuse_in ? 14'h0 : bstart(boot_size_fuses_in)))
    else $error("reset vector wrong");
endmodule : bfg_guard_assertions

bind bfg_guard bfg_guard_assertions #(.AW(AW)) u_chk (.*);

// ### dv/bfg_guard_tb.sv
/*
  testbench of the guard: random stores plus lock, load and mask corners.
  assumes boot size fuses 3, so the boot section starts at word 3F00.
*/
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module bfg_guard_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rst_n_in, boot_reset_fuse_in, vectors_in_boot_in, cmd_wr_in, load_req_in;
  logic program_memory_store_in, flash_done_in, lock_load_in, ext_lock_wr_in, chip_erase_in;
  logic [1:0] boot_size_fuses_in;
  logic [4:0] cmd_data_in;
  logic [13:0] exec_addr_in, store_addr_in, load_addr_in, reset_vector_out, pg;
  logic [4:0] cmd_rand; // random erase or write code
  bfg_pkg::bfg_lock_t store_lock_data_in, lock_nvm_in, ext_lock_data_in, lock_bits_out;
  bfg_pkg::bfg_flash_req_t flash_req_out;
  bfg_pkg::bfg_load_ans_t load_ans_out;
  logic buf_load_out, buf_clear_out, core_halt_out, rw_section_busy_flag_out;
  logic rww_read_block_out, halting_section_read_block_out, store_refused_out, irq_mask_out;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h17;
  bfg_guard DUT (.*);
  bfg_core_model core (.clk_in(clk_in), .flash_req_in(flash_req_out), .cmd_wr_out(cmd_wr_in),
    .cmd_data_out(cmd_data_in), .store_out(program_memory_store_in),
    .store_addr_out(store_addr_in), .lock_data_out(store_lock_data_in),
    .flash_done_out(flash_done_in));
  // xorshift source, fixed start keeps runs repeatable
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected: execution inside the boot section
  function automatic logic in_boot(input logic [13:0] a);
    return a >= 14'h3F00;
  endfunction : in_boot
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // store with the shortest gap; returns while the one-cycle answer stands
  task spm_chk(input logic [4:0] c, input logic [13:0] a, input logic [3:0] l);
    core.program_memory_store(c, a, l, 1);
  endtask : spm_chk
  // load pulse; an edge passes first so back-to-back loads never retoggle
  // the strobe in one step, and it returns while the answer stands
  task load(input logic [13:0] a);
    @(negedge clk_in);
    load_req_in = 1'h1;
    load_addr_in = a;
    @(negedge clk_in);
    load_req_in = 1'h0;
    load_addr_in = ~a;
  endtask : load
  // bounded wait for the array, a lapse ends the run
  task wait_done();
    int i;
    for (i = 0; i < 40 && flash_done_in !== 1'h1; i++) @(negedge clk_in);
    if (i == 40) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : wait_done
  task ext(input logic [3:0] l);
    ext_lock_wr_in = 1'h1;
    ext_lock_data_in = l;
    @(negedge clk_in);
    ext_lock_wr_in = 1'h0;
    ext_lock_data_in = ~l;
    @(negedge clk_in);
  endtask : ext
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    {rst_n_in, boot_reset_fuse_in, vectors_in_boot_in, load_req_in} = 4'h4;
    {lock_load_in, ext_lock_wr_in, chip_erase_in} = 3'h0;
    boot_size_fuses_in = 2'h3;
    exec_addr_in = 14'h0;
    load_addr_in = 14'h0;
    lock_nvm_in = 4'hF;
    ext_lock_data_in = 4'hF;
    repeat (4) @(negedge clk_in);
    rst_n_in = 1'h1;
    @(negedge clk_in);
    `CHK("lock", 4'hF, lock_bits_out)
    `CHK("vector", 14'h0, reset_vector_out)
    boot_reset_fuse_in = 1'h0;
    @(negedge clk_in);
    `CHK("vector", 14'h3F00, reset_vector_out)
    boot_size_fuses_in = 2'h0;
    @(negedge clk_in);
    `CHK("vector", 14'h3800, reset_vector_out)
    boot_size_fuses_in = 2'h3;
    $display("test reset done");
    // random stores from either section, gap 1 to 4
    for (int k = 0; k < 16; k++) begin
      exec_addr_in = seed[0] ? (14'h3F00 | seed[15:8]) : 14'(seed[31:8] % 24'h3F00);
      pg = 14'(rnd());
      cmd_rand = (rnd() % 2 != 0) ? 5'h05 : 5'h03;
      core.program_memory_store(cmd_rand, pg, 4'hF, 1 + rnd() % 4);
      `CHK("start", in_boot(exec_addr_in), flash_req_out.start)
      `CHK("refused", !in_boot(exec_addr_in), store_refused_out)
      if (in_boot(exec_addr_in)) begin
        `CHK("halt", pg >= 14'h3800, core_halt_out)
        `CHK("halting block", pg >= 14'h3800, halting_section_read_block_out)
        `CHK("busy", 1'h1, rw_section_busy_flag_out)
        `CHK("rww block", 1'h1, rww_read_block_out)
        `CHK("page", pg, flash_req_out.page)
        `CHK("op", (cmd_rand == 5'h05) ? bfg_pkg::BFG_OP_WRITE : bfg_pkg::BFG_OP_ERASE, flash_req_out.op)
        load(14'h3900);
        `CHK("halting read", pg < 14'h3800, load_ans_out.ok)
        load(14'h0100);
        `CHK("rww read", 1'h1, load_ans_out.deny)
        wait_done();
        `CHK("busy kept", 1'h1, rw_section_busy_flag_out)
        spm_chk(5'h11, 14'h0, 4'hF);
        `CHK("busy clear", 1'h0, rw_section_busy_flag_out)
        `CHK("buffer clear", 1'h1, buf_clear_out)
      end
    end
    $display("test random stores done");
    exec_addr_in = 14'h3F00;
    core.program_memory_store(5'h03, 14'h3F40, 4'hF, 5);
    `CHK("late store", 1'h0, flash_req_out.start)
    spm_chk(5'h01, 14'h0010, 4'hF);
    `CHK("buffer load", 1'h1, buf_load_out)
    spm_chk(5'h09, 14'h0, 4'hE);
    `CHK("lock", 4'hE, lock_bits_out)
    spm_chk(5'h03, 14'h0200, 4'hF);
    `CHK("app store", 1'h1, store_refused_out)
    `CHK("no stall", 1'h0, core_halt_out)
    spm_chk(5'h03, 14'h3F40, 4'hF);
    `CHK("boot store", 1'h1, flash_req_out.start)
    wait_done();
    spm_chk(5'h11, 14'h0, 4'hF);
    spm_chk(5'h09, 14'h0, 4'hB);
    `CHK("lock", 4'hA, lock_bits_out)
    spm_chk(5'h05, 14'h3F40, 4'hF);
    `CHK("boot store", 1'h1, store_refused_out)
    ext(4'hF);
    `CHK("lock", 4'hA, lock_bits_out)
    chip_erase_in = 1'h1;
    @(negedge clk_in);
    chip_erase_in = 1'h0;
    `CHK("lock", 4'hF, lock_bits_out)
    $display("test locks done");
    ext(4'h5);
    load(14'h0200);
    `CHK("boot to app", 1'h1, load_ans_out.deny)
    load(14'h3F10);
    `CHK("boot to boot", 1'h1, load_ans_out.ok)
    exec_addr_in = 14'h0100;
    load(14'h3F10);
    `CHK("app to boot", 1'h1, load_ans_out.deny)
    vectors_in_boot_in = 1'h1;
    @(negedge clk_in);
    `CHK("mask", 1'h1, irq_mask_out)
    exec_addr_in = 14'h3F00;
    @(negedge clk_in);
    `CHK("mask", 1'h0, irq_mask_out)
    vectors_in_boot_in = 1'h0;
    @(negedge clk_in);
    `CHK("mask", 1'h1, irq_mask_out)
    // stored lock bits copied in replace the live word, raised bits included
    lock_nvm_in = 4'h3;
    lock_load_in = 1'h1;
    @(negedge clk_in);
    lock_load_in = 1'h0;
    `CHK("lock load", 4'h3, lock_bits_out)
    $display("test loads and masks done");
    tally_and_finish();
  end
endmodule : bfg_guard_tb

// ### rtl/bfg_guard.sv
/*
  boot flash self-program guard: takes program-memory store and load
  requests from the core, applies section and lock checks, starts flash
  erase and write, stalls the core, keeps the busy flag and masks interrupts.
  assumes all inputs come from logic on clk_in; flash_done_in pulses once
  when the array finishes an erase or write.
*/
`include "bfg_regs.svh"

module bfg_guard #(
  parameter int AW = `BFG_AW
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // fuses and vector placement
  input wire logic [1:0] boot_size_fuses_in,
  input wire logic boot_reset_fuse_in,
  input wire logic vectors_in_boot_in,
  // core execution state
  input wire logic [AW-1:0] exec_addr_in,
  // self-program control word write
  input wire logic cmd_wr_in,
  input wire logic [`BFG_CMD_W-1:0] cmd_data_in,
  // program-memory store
  input wire logic program_memory_store_in,
  input wire logic [AW-1:0] store_addr_in,
  input wire bfg_pkg::bfg_lock_t store_lock_data_in,
  // program-memory load
  input wire logic load_req_in,
  input wire logic [AW-1:0] load_addr_in,
  // flash array and lock storage
  input wire logic flash_done_in,
  input wire logic lock_load_in,
  input wire bfg_pkg::bfg_lock_t lock_nvm_in,
  input wire logic ext_lock_wr_in,
  input wire bfg_pkg::bfg_lock_t ext_lock_data_in,
  input wire logic chip_erase_in,
  // flash array requests
  output bfg_pkg::bfg_flash_req_t flash_req_out,
  output logic buf_load_out,
  output logic buf_clear_out,
  // core control and status
  output logic core_halt_out,
  output logic rw_section_busy_flag_out,
  output logic rww_read_block_out,
  output logic halting_section_read_block_out,
  output logic store_refused_out,
  output bfg_pkg::bfg_load_ans_t load_ans_out,
  output logic irq_mask_out,
  output bfg_pkg::bfg_lock_t lock_bits_out,
  output logic [AW-1:0] reset_vector_out
);

  // whole state of the block
  typedef struct packed {
    bfg_pkg::bfg_phase_t phase;          // array activity
    logic halt;                          // core stall, registered decode of the halting-section phase
    bfg_pkg::bfg_lock_t lock;            // boot lock pairs
    logic busy;                          // read-while-write busy flag
    logic [2:0] win_cnt;                 // store window left
    logic [`BFG_CMD_W-1:0] cmd;          // latched command
    bfg_pkg::bfg_flash_req_t req;        // pulse to the array
    logic buf_load;                      // page buffer write pulse
    logic buf_clear;                     // page buffer clear pulse
    logic refused;                       // store refused pulse
    bfg_pkg::bfg_load_ans_t load_ans;    // load answer pulse
    logic irq_mask;                      // interrupt mask level
    logic [AW-1:0] reset_vector;         // fetch address after reset
  } bfg_state_t;

  bfg_state_t s_reg;
  bfg_state_t s_next;

  // section decode of executing, store and load addresses
  logic exec_boot;
  logic store_boot;
  logic store_halting_section;
  logic load_boot;
  logic load_halting_section;
  logic [AW-1:0] boot_start;
  logic store_allow;
  logic load_allow;

  // executing address; also gives the boot start for the reset vector
  bfg_section_map #(.AW(AW)) u_map_exec (
    .addr_in(exec_addr_in),
    .boot_size_fuses_in(boot_size_fuses_in),
    .in_boot_out(exec_boot),
    .in_halting_section_out(),
    .boot_start_out(boot_start)
  );

  // store target
  bfg_section_map #(.AW(AW)) u_map_store (
    .addr_in(store_addr_in),
    .boot_size_fuses_in(boot_size_fuses_in),
    .in_boot_out(store_boot),
    .in_halting_section_out(store_halting_section),
    .boot_start_out()
  );

  // load target
  bfg_section_map #(.AW(AW)) u_map_load (
    .addr_in(load_addr_in),
    .boot_size_fuses_in(boot_size_fuses_in),
    .in_boot_out(load_boot),
    .in_halting_section_out(load_halting_section),
    .boot_start_out()
  );

  // store verdict; stores only ever run from boot code
  bfg_lock_check u_chk_store (
    .lock_in(s_reg.lock),
    .exec_in_boot_in(1'b1),
    .tgt_in_boot_in(store_boot),
    .is_load_in(1'b0),
    .allow_out(store_allow)
  );

  // load verdict
  bfg_lock_check u_chk_load (
    .lock_in(s_reg.lock),
    .exec_in_boot_in(exec_boot),
    .tgt_in_boot_in(load_boot),
    .is_load_in(1'b1),
    .allow_out(load_allow)
  );

  // next state
  always_comb begin
    s_next = s_reg;
    // pulses drop back unless raised below
    s_next.req.start = 1'b0;
    s_next.buf_load = 1'b0;
    s_next.buf_clear = 1'b0;
    s_next.refused = 1'b0;
    s_next.load_ans = '0;

    if (cmd_wr_in) begin
      s_next.cmd = cmd_data_in;
      s_next.win_cnt = `BFG_SPM_WINDOW_CYC;
    end else if (s_reg.win_cnt != 3'h0) begin
      s_next.win_cnt = s_reg.win_cnt - 3'h1;
    end

    // array finished: core resumes, busy flag stays for software
    if (s_reg.phase != bfg_pkg::BFG_IDLE && flash_done_in) begin
      s_next.phase = bfg_pkg::BFG_IDLE;
    end

    // store outside the window or with no command does nothing at all
    if (program_memory_store_in && s_reg.win_cnt != 3'h0 && !cmd_wr_in) begin
      s_next.win_cnt = 3'h0;
      if (!exec_boot) begin
        s_next.refused = 1'b1;
      end else if (s_reg.phase != bfg_pkg::BFG_IDLE) begin
        // one operation at a time; a second store is dropped
        s_next.refused = 1'b1;
      end else begin
        unique case (s_reg.cmd)
          `BFG_CMD_ERASE,
          `BFG_CMD_WRITE: begin
            if (store_allow) begin
              s_next.req.start = 1'b1;
              s_next.req.page = store_addr_in;
              s_next.req.op = (s_reg.cmd == `BFG_CMD_ERASE) ?
                bfg_pkg::BFG_OP_ERASE : bfg_pkg::BFG_OP_WRITE;
              s_next.phase = store_halting_section ? bfg_pkg::BFG_BUSY_HALTING_SECTION
                                        : bfg_pkg::BFG_BUSY_RWW;
              s_next.busy = 1'b1;
            end else begin
              s_next.refused = 1'b1;
            end
          end
          `BFG_CMD_BUF_LOAD: begin
            // page buffer fill, no array access
            s_next.buf_load = 1'b1;
          end
          `BFG_CMD_LOCK_SET: begin
            s_next.lock = s_reg.lock & store_lock_data_in;
          end
          `BFG_CMD_RW_ENABLE: begin
            s_next.busy = 1'b0;
            s_next.buf_clear = 1'b1;
          end
          default: begin
            // unknown code: store has no effect
            s_next.refused = 1'b1;
          end
        endcase
      end
    end

    // external programming may also program lock bits
    if (ext_lock_wr_in) begin
      s_next.lock = s_next.lock & ext_lock_data_in;
    end
    // lock storage copied in after reset release
    if (lock_load_in) begin
      s_next.lock = lock_nvm_in;
    end
    if (chip_erase_in) begin
      s_next.lock = `BFG_LOCK_RST;
    end

    // load answer; general locks never checked here
    if (load_req_in) begin
      if (s_reg.phase == bfg_pkg::BFG_BUSY_HALTING_SECTION ||
          (!load_halting_section && (s_reg.busy || s_reg.phase != bfg_pkg::BFG_IDLE)) ||
          !load_allow) begin
        s_next.load_ans.deny = 1'b1;
      end else begin
        s_next.load_ans.ok = 1'b1;
      end
    end

    s_next.irq_mask =
      (vectors_in_boot_in && !exec_boot && !s_reg.lock.app_read_protect_bit) ||
      (!vectors_in_boot_in && exec_boot && !s_reg.lock.boot_read_protect_bit);

    // halt held in a flop
    // decoded here so the stall output leaves the block with no logic after it
    s_next.halt = s_next.phase == bfg_pkg::BFG_BUSY_HALTING_SECTION;

    s_next.reset_vector = boot_reset_fuse_in ? '0 : boot_start;
  end

  // state register; locks start unprogrammed until storage is copied in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg.phase <= bfg_pkg::BFG_IDLE;
      s_reg.halt <= 1'b0;
      s_reg.lock <= `BFG_LOCK_RST;
      s_reg.busy <= 1'b0;
      s_reg.win_cnt <= 3'h0;
      s_reg.cmd <= `BFG_CMD_RST;
      s_reg.req <= '0;
      s_reg.buf_load <= 1'b0;
      s_reg.buf_clear <= 1'b0;
      s_reg.refused <= 1'b0;
      s_reg.load_ans <= '0;
      s_reg.irq_mask <= 1'b0;
      s_reg.reset_vector <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign flash_req_out = s_reg.req;
  assign buf_load_out = s_reg.buf_load;
  assign buf_clear_out = s_reg.buf_clear;
  assign core_halt_out = s_reg.halt;
  assign rw_section_busy_flag_out = s_reg.busy;
  assign rww_read_block_out = s_reg.busy;
  assign halting_section_read_block_out = s_reg.halt;
  assign store_refused_out = s_reg.refused;
  assign load_ans_out = s_reg.load_ans;
  assign irq_mask_out = s_reg.irq_mask;
  assign lock_bits_out = s_reg.lock;
  assign reset_vector_out = s_reg.reset_vector;

endmodule : bfg_guard

// ### rtl/bfg_lock_check.sv
/*
  lock check: decides whether a store or load is allowed by the two lock
  pairs, from where it executes and what it targets.
  assumes the caller already refused stores executed from the application.
*/
module bfg_lock_check (
  // access description
  input wire bfg_pkg::bfg_lock_t lock_in,
  input wire logic exec_in_boot_in,
  input wire logic tgt_in_boot_in,
  input wire logic is_load_in,
  // verdict
  output logic allow_out
);
  // only the boot lock pairs matter; general lock modes never enter here
  always_comb begin
    allow_out = 1'b1;
    if (!is_load_in) begin
      if (!tgt_in_boot_in && !lock_in.app_write_protect_bit) begin
        allow_out = 1'b0;
      end
      if (tgt_in_boot_in && !lock_in.boot_write_protect_bit) begin
        allow_out = 1'b0;
      end
    end else begin
      if (exec_in_boot_in && !tgt_in_boot_in && !lock_in.app_read_protect_bit) begin
        allow_out = 1'b0;
      end
      if (!exec_in_boot_in && tgt_in_boot_in && !lock_in.boot_read_protect_bit) begin
        allow_out = 1'b0;
      end
    end
  end
endmodule : bfg_lock_check

// ### rtl/bfg_section_map.sv
/*
  section map: tells whether a flash word address lies in the boot section
  and in the halting section, and where the boot section starts.
  assumes fuses are steady levels from the fuse block on the same clock.
*/
`include "bfg_regs.svh"

module bfg_section_map #(
  parameter int AW = `BFG_AW,
  parameter logic [AW-1:0] HALTING_SECTION_START = 14'h3800,
  parameter logic [AW:0] BOOT_W3 = 15'h0100,
  parameter logic [AW:0] BOOT_W2 = 15'h0200,
  parameter logic [AW:0] BOOT_W1 = 15'h0400,
  parameter logic [AW:0] BOOT_W0 = 15'h0800
) (
  // address and fuses
  input wire logic [AW-1:0] addr_in,
  input wire logic [1:0] boot_size_fuses_in,
  // decode
  output logic in_boot_out,
  output logic in_halting_section_out,
  output logic [AW-1:0] boot_start_out
);
  localparam logic [AW:0] FLASH_WORDS = (AW+1)'(1) << AW;
  logic [AW:0] size;
  logic [AW:0] raw_start;

  // boot size from the fuses, start counted down from the top
  always_comb begin
    unique case (boot_size_fuses_in)
      2'h3: size = BOOT_W3;
      2'h2: size = BOOT_W2;
      2'h1: size = BOOT_W1;
      2'h0: size = BOOT_W0;
    endcase
    raw_start = FLASH_WORDS - size;
    if (raw_start[AW-1:0] < HALTING_SECTION_START || raw_start[AW]) begin
      boot_start_out = HALTING_SECTION_START;
    end else begin
      boot_start_out = raw_start[AW-1:0];
    end
    in_boot_out = addr_in >= boot_start_out;
    in_halting_section_out = addr_in >= HALTING_SECTION_START;
  end
endmodule : bfg_section_map

// ### shared/bfg_pkg.sv
/*
  types of the boot flash self-program guard.
  assumes bfg_regs.svh supplies the widths.
*/
`include "bfg_regs.svh"

package bfg_pkg;

  // programming phase of the flash array
  typedef enum logic [1:0] {
    BFG_IDLE,
    BFG_BUSY_RWW,
    BFG_BUSY_HALTING_SECTION
  } bfg_phase_t;

  // operation handed to the flash array
  typedef enum logic [0:0] {
    BFG_OP_ERASE,
    BFG_OP_WRITE
  } bfg_op_t;

  // lock word, zero means programmed
  typedef struct packed {
    logic boot_read_protect_bit;
    logic boot_write_protect_bit;
    logic app_read_protect_bit;
    logic app_write_protect_bit;
  } bfg_lock_t;

  // request to the flash array
  typedef struct packed {
    logic start;
    bfg_op_t op;
    logic [`BFG_AW-1:0] page;
  } bfg_flash_req_t;

  // answer to a program-memory load
  typedef struct packed {
    logic ok;
    logic deny;
  } bfg_load_ans_t;

endpackage : bfg_pkg

// ### shared/bfg_regs.svh
/*
  constants of the boot flash self-program guard: command codes, lock layout,
  reset values and the store window count.
  assumes it is included by bare name before the package or inside modules.
*/
`ifndef BFG_REGS_SVH
`define BFG_REGS_SVH

// word address width of program flash
`define BFG_AW 14
// command codes held in the low bits of the self-program control word
`define BFG_CMD_W 5
`define BFG_CMD_BUF_LOAD 5'h01
`define BFG_CMD_ERASE 5'h03
`define BFG_CMD_WRITE 5'h05
`define BFG_CMD_LOCK_SET 5'h09
`define BFG_CMD_RW_ENABLE 5'h11
// lock bit positions inside the four-bit lock word
`define BFG_LOCK_APP_WR 0
`define BFG_LOCK_APP_RD 1
`define BFG_LOCK_BOOT_WR 2
`define BFG_LOCK_BOOT_RD 3
// all lock bits unprogrammed
`define BFG_LOCK_RST 4'hF
// cycles after the command write in which a store is still taken
`define BFG_SPM_WINDOW_CYC 3'h4
// reset value of the command word
`define BFG_CMD_RST 5'h00

`endif
